// File: bench/display_memory_access_mux_sva.sv
// assertion checker for the display memory access fabric
`timescale 1ns/1ps
`default_nettype none
module display_memory_access_mux_chk #(
	parameter int AW = 10,
	parameter int WORDS = 1024
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [15:0] cpu_addr_in,
	input wire logic [7:0] cpu_data_in,
	input wire logic cpu_read_direction_n_in,
	input wire logic cpu_access_in,
	input wire logic write_clock_in,
	input wire logic memory_owner_out,
	input wire logic rom_enable_n_out,
	input wire logic [2:0] xcvr_enable_n_out,
	input wire logic stroke_cs_n_out,
	input wire logic [15:0] mem_data_out,
	input wire logic upper_lane_direction_out,
	input wire logic lower_lane_direction_out,
	input wire logic blank_lane_direction_out,
	input wire logic system_direction_out,
	input wire logic [10:0] latch_strobe_out,
	input wire logic fast_sweep_enable_out,
	input wire logic [15:0] scan_word_out,
	input wire logic scan_word_valid_out,
	input wire logic cpu_clock_out,
	input wire logic character_dot_clock_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire logic [3:0] dir_n = {upper_lane_direction_out, lower_lane_direction_out,
		blank_lane_direction_out, system_direction_out};
	// ******************************
	// half period counters
	// ******************************
	// the first edge after reset is skipped: the divider phase is not known there
	logic [6:0] dot_cnt_reg, cpu_cnt_reg;
	logic dot_prev_reg, cpu_prev_reg, dot_seen_reg, cpu_seen_reg;
	always_ff @(posedge clk_in) begin
		dot_prev_reg <= character_dot_clock_out;
		cpu_prev_reg <= cpu_clock_out;
		dot_cnt_reg <= (character_dot_clock_out != dot_prev_reg) ? 7'h00 : dot_cnt_reg + 7'h01;
		cpu_cnt_reg <= (cpu_clock_out != cpu_prev_reg) ? 7'h00 : cpu_cnt_reg + 7'h01;
		dot_seen_reg <= !reset_in && (dot_seen_reg || character_dot_clock_out != dot_prev_reg);
		cpu_seen_reg <= !reset_in && (cpu_seen_reg || cpu_clock_out != cpu_prev_reg);
	end
	// ******************************
	// properties
	// ******************************
	a_rom_follows_owner: assert property (rom_enable_n_out == memory_owner_out)
		else $error("rom enable does not follow owner");
	a_xcvr_single: assert property ($onehot0(~xcvr_enable_n_out))
		else $error("more than one transceiver enabled");
	a_xcvr_cause: assert property (xcvr_enable_n_out != 3'h7 |-> $past(cpu_access_in) && $past(memory_owner_out))
		else $error("transceiver enabled without cpu ownership");
	a_dir_single: assert property ($onehot0(~dir_n))
		else $error("two direction commands at once");
	a_dir_cause: assert property (dir_n != 4'hf |-> $past(cpu_read_direction_n_in) && !$past(write_clock_in) && $past(cpu_addr_in) < 16'h8000)
		else $error("direction command without cause");
	a_upper_byte: assert property (!upper_lane_direction_out |-> !xcvr_enable_n_out[0] && mem_data_out[15:8] == $past(cpu_data_in))
		else $error("upper byte lane wrong");
	a_lower_nibble: assert property (!lower_lane_direction_out |-> !xcvr_enable_n_out[1] && mem_data_out[7:4] == $past(cpu_data_in) >> 4)
		else $error("lower nibble lane wrong");
	a_blank_nibble: assert property (!blank_lane_direction_out |-> !xcvr_enable_n_out[2] && mem_data_out[3:0] == $past(cpu_data_in) >> 4)
		else $error("blanking nibble lane wrong");
	a_stroke_cpu: assert property (cpu_access_in && memory_owner_out && cpu_addr_in[15:12] == 4'h0 && cpu_addr_in[11:10] != 2'h0 |=> !stroke_cs_n_out)
		else $error("stroke select missing");
	a_trigger_strobe: assert property (latch_strobe_out[4] |-> $past(cpu_access_in) && $past(cpu_addr_in) == 16'h0019)
		else $error("trigger strobe without its address");
	a_fast_on_cause: assert property ($rose(fast_sweep_enable_out) |-> $past(cpu_addr_in) == 16'h0017)
		else $error("fast sweep set by wrong address");
	a_fraction_zero: assert property (scan_word_valid_out |-> scan_word_out[5:4] == 2'h0)
		else $error("averaging fraction reached display");
	a_dot_rate: assert property (dot_seen_reg && character_dot_clock_out != dot_prev_reg |-> dot_cnt_reg == 7'd24)
		else $error("dot clock half period wrong");
	a_cpu_rate: assert property (cpu_seen_reg && cpu_clock_out != cpu_prev_reg |-> cpu_cnt_reg == 7'd49)
		else $error("cpu clock half period wrong");
endmodule : display_memory_access_mux_chk
bind display_memory_access_mux display_memory_access_mux_chk #(.AW(AW), .WORDS(WORDS)) chk (.*);
`default_nettype wire

// File: bench/system_ram_model.sv
// system ram model on the far side of the fabric
`timescale 1ns/1ps
`default_nettype none
module system_ram_model (
	input wire logic clk_in,
	input wire logic sel_n_in,
	input wire logic dir_in,
	input wire logic [9:0] addr_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] rdata_out
);
	logic [15:0] mem [0:1023];
	logic [15:0] last_reg = 16'h0000;
	// unselected bus shows the inverse of the last word, never a stale copy
	assign rdata_out = sel_n_in ? ~last_reg : mem[addr_in];
	always_ff @(posedge clk_in) begin
		if (!sel_n_in) begin
			last_reg <= mem[addr_in];
		end
		if (!sel_n_in && !dir_in) begin
			mem[addr_in] <= wdata_in;
		end
	end
endmodule : system_ram_model
`default_nettype wire

// File: bench/tb_display_memory_access_mux.sv
// self-checking bench for the display memory access fabric
`timescale 1ns/1ps
`default_nettype none
module tb_display_memory_access_mux;
	logic clk_in = 1'b0, reset_in = 1'b1, cpu_read_direction_n_in = 1'b1, cpu_access_in = 1'b0;
	logic write_clock_in = 1'b0, scan_request_in = 1'b0;
	logic [15:0] cpu_addr_in = 16'h0000, scan_count_in = 16'h0000, sys_rdata_in;
	logic [7:0] cpu_data_in = 8'h00, cpu_data_out;
	logic memory_owner_out, rom_enable_n_out, stroke_cs_n_out, system_cs_n_out, mem_data_oe_n_out;
	logic [2:0] xcvr_enable_n_out;
	logic [9:0] mem_addr_out;
	logic [15:0] mem_data_out, scan_word_out;
	logic upper_lane_direction_out, lower_lane_direction_out, blank_lane_direction_out;
	logic system_direction_out, fast_sweep_enable_out, scan_word_valid_out, scan_blank_out;
	logic cpu_clock_out, character_dot_clock_out;
	logic [10:0] latch_strobe_out;
	int error_cnt = 0, check_count = 0;
	display_memory_access_mux #(.AW(10), .WORDS(1024)) uut (.*);
	system_ram_model ram (.clk_in(clk_in), .sel_n_in(system_cs_n_out), .dir_in(system_direction_out),
		.addr_in(mem_addr_out), .wdata_in(mem_data_out), .rdata_out(sys_rdata_in));
	always #2.5 clk_in = ~clk_in;
	// ******************************
	// helpers
	// ******************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic final_report();
		if (error_cnt == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	task automatic tick();
		@(posedge clk_in);
		#1;
	endtask : tick
	// request stays up on return so that the next access follows back to back
	task automatic cpu_op(input logic [15:0] a, input logic [7:0] d, input logic rd_n);
		int n;
		cpu_addr_in = a;
		cpu_data_in = d;
		cpu_read_direction_n_in = rd_n;
		cpu_access_in = 1'b1;
		n = 0;
		while (memory_owner_out !== 1'b1 && n < 50) begin
			tick();
			n++;
		end
		tick();
	endtask : cpu_op
	task automatic scan_read(input logic [15:0] cnt, output logic [15:0] w, output logic b);
		int n;
		scan_count_in = cnt;
		scan_request_in = 1'b1;
		n = 0;
		while (scan_word_valid_out !== 1'b1 && n < 100) begin
			tick();
			n++;
		end
		w = scan_word_out;
		b = scan_blank_out;
		scan_request_in = 1'b0;
		tick();
	endtask : scan_read
	// ******************************
	// scenarios
	// ******************************
	task automatic t_reset();
		check({9'h0, memory_owner_out, rom_enable_n_out, xcvr_enable_n_out, stroke_cs_n_out,
			system_cs_n_out}, 16'h001f);
		check({5'h0, latch_strobe_out}, 16'h0000);
		check({15'h0, scan_blank_out}, 16'h0001);
	endtask : t_reset
	task automatic t_stroke();
		logic [15:0] w;
		logic b;
		cpu_op(16'h0a40, 8'ha5, 1'b1);
		check({10'h0, xcvr_enable_n_out, stroke_cs_n_out, upper_lane_direction_out,
			mem_data_oe_n_out}, 16'h0030);
		check({8'h0, mem_data_out[15:8]}, 16'h00a5);
		check({6'h0, mem_addr_out}, 16'h0240);
		// the counter asks for memory in mid transfer and must wait
		scan_request_in = 1'b1;
		cpu_op(16'h0e40, 8'h9c, 1'b1);
		check({12'h0, xcvr_enable_n_out, lower_lane_direction_out}, 16'h000a);
		check({12'h0, mem_data_out[7:4]}, 16'h0009);
		check({15'h0, memory_owner_out}, 16'h0001);
		cpu_op(16'h0640, 8'h36, 1'b1);
		check({12'h0, xcvr_enable_n_out, blank_lane_direction_out}, 16'h0006);
		check({12'h0, mem_data_out[3:0]}, 16'h0003);
		cpu_access_in = 1'b0;
		scan_read(16'h8800, w, b);
		check(w, 16'ha583);
		cpu_op(16'h0a40, 8'h00, 1'b0);
		check({8'h0, cpu_data_out}, 16'h00a5);
		cpu_op(16'h0e40, 8'h00, 1'b0);
		check({15'h0, mem_data_oe_n_out}, 16'h0001);
		check({8'h0, cpu_data_out}, 16'h0090);
		cpu_op(16'h0640, 8'h00, 1'b0);
		check({8'h0, cpu_data_out}, 16'h0030);
		cpu_access_in = 1'b0;
	endtask : t_stroke
	task automatic t_edges();
		logic [15:0] w;
		logic b;
		logic [8:0] pos [4] = '{9'h00f, 9'h010, 9'h1f0, 9'h1f1};
		for (int i = 0; i < 4; i++) begin
			scan_read({2'h0, pos[i], 5'h00}, w, b);
			check({15'h0, b}, {15'h0, pos[i] < 9'h010 || pos[i] > 9'h1f0});
		end
	endtask : t_edges
	task automatic t_system();
		cpu_op(16'h0380, 8'h5c, 1'b1);
		check({9'h0, xcvr_enable_n_out, system_cs_n_out, system_direction_out, stroke_cs_n_out,
			rom_enable_n_out}, 16'h0063);
		cpu_access_in = 1'b0;
		write_clock_in = 1'b1;
		tick();
		cpu_op(16'h0381, 8'h11, 1'b1);
		check({12'h0, upper_lane_direction_out, lower_lane_direction_out, blank_lane_direction_out,
			system_direction_out}, 16'h000f);
		write_clock_in = 1'b0;
		cpu_op(16'h0380, 8'h00, 1'b0);
		cpu_access_in = 1'b0;
		tick();
		tick();
		check({8'h0, cpu_data_out}, 16'h005c);
	endtask : t_system
	task automatic t_latch();
		for (int a = 16'h0015; a <= 16'h001f; a++) begin
			cpu_op(a[15:0], 8'h00, 1'b1);
			check({5'h0, latch_strobe_out}, 16'h0001 << (a - 16'h0015));
			check({15'h0, fast_sweep_enable_out}, {15'h0, a >= 16'h0017});
		end
		cpu_access_in = 1'b0;
	endtask : t_latch
	// the scenarios need well under 2000 cycles; this leaves ample margin
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge clk_in);
		#1;
		t_reset();
		reset_in = 1'b0;
		tick();
		t_stroke();
		t_edges();
		t_system();
		t_latch();
		tick();
		final_report();
	end
endmodule : tb_display_memory_access_mux
`default_nettype wire

// File: verilog/clock_divider.sv
// square wave divider from the fabric clock
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(
	parameter int HALF = 50
) (
	input wire logic clk_in,
	input wire logic reset_in,
	output logic tick_out,
	output logic wave_out
);
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic wave_reg;
	logic wave_next;
	logic tick_next;
	logic tick_reg;
	always_comb begin
		count_next = count_reg + 16'h0001;
		wave_next = wave_reg;
		tick_next = 1'b0;
		if (count_reg == 16'(HALF - 1)) begin
			count_next = 16'h0000;
			wave_next = ~wave_reg;
			tick_next = wave_reg;
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			count_reg <= 16'h0000;
			wave_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			wave_reg <= wave_next;
			tick_reg <= tick_next;
		end
	end
	assign tick_out = tick_reg;
	assign wave_out = wave_reg;
endmodule : clock_divider
`default_nettype wire

// File: verilog/display_memory_access_mux.sv
// memory access fabric: ownership, byte widening, selects, stroke store
`timescale 1ns/1ps
`default_nettype none
`include "memory_fabric_map.svh"
module display_memory_access_mux
	import memory_fabric_pkg::*;
#(
	parameter int AW = 10,
	parameter int WORDS = 1024
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [15:0] cpu_addr_in,
	input wire logic [7:0] cpu_data_in,
	input wire logic cpu_read_direction_n_in,
	input wire logic cpu_access_in,
	input wire logic write_clock_in,
	input wire logic scan_request_in,
	input wire logic [15:0] scan_count_in,
	input wire logic [15:0] sys_rdata_in,
	output logic [7:0] cpu_data_out,
	output logic memory_owner_out,
	output logic rom_enable_n_out,
	output logic [2:0] xcvr_enable_n_out,
	output logic stroke_cs_n_out,
	output logic system_cs_n_out,
	output logic [AW-1:0] mem_addr_out,
	output logic [15:0] mem_data_out,
	output logic mem_data_oe_n_out,
	output logic upper_lane_direction_out,
	output logic lower_lane_direction_out,
	output logic blank_lane_direction_out,
	output logic system_direction_out,
	output logic [10:0] latch_strobe_out,
	output logic fast_sweep_enable_out,
	output logic [15:0] scan_word_out,
	output logic scan_word_valid_out,
	output logic scan_blank_out,
	output logic cpu_clock_out,
	output logic character_dot_clock_out
);
	// ************************************************************
	// address decode helpers
	// ************************************************************
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	function automatic logic [2:0] xcvr_decode(input logic owner, input logic [15:0] a);
		xcvr_decode = 3'b111;
		if (owner) begin
			unique case (a[11:10])
				2'b00: xcvr_decode = 3'b111;
				2'b01: xcvr_decode = 3'b011;
				2'b10: xcvr_decode = 3'b110;
				2'b11: xcvr_decode = 3'b101;
			endcase
		end
	endfunction : xcvr_decode

	// ************************************************************
	// clocks
	// ************************************************************
	logic cpu_tick;
	logic cpu_wave;
	logic dot_wave;
	clock_divider #(.HALF(`CPU_CLOCK_HALF)) cpu_div (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.tick_out(cpu_tick),
		.wave_out(cpu_wave)
	);
	clock_divider #(.HALF(`DOT_CLOCK_HALF)) dot_div (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.tick_out(),
		.wave_out(dot_wave)
	);

	// ************************************************************
	// stroke store
	// ************************************************************
	// 1024 words of 16 bits
	logic [15:0] stroke_mem [WORDS];
	logic sys_read_reg;
	logic sys_read_next;
	logic [15:0] sys_word;
	assign sys_word = sys_rdata_in;

	// ************************************************************
	// ownership and transfer state
	// ************************************************************
	owner_e owner_reg;
	owner_e owner_next;
	logic cpu_busy_reg;
	logic cpu_busy_next;
	logic [1:0] steps_left_reg;
	logic [1:0] steps_left_next;
	logic fast_reg;
	logic fast_next;
	logic [7:0] cpu_data_reg;
	logic [7:0] cpu_data_next;
	logic [2:0] xcvr_reg;
	logic [2:0] xcvr_next;
	logic stroke_cs_reg;
	logic stroke_cs_next;
	logic system_cs_reg;
	logic system_cs_next;
	logic [AW-1:0] addr_reg;
	logic [AW-1:0] addr_next;
	logic [15:0] wdata_reg;
	logic [15:0] wdata_next;
	logic oe_n_reg;
	logic oe_n_next;
	logic [3:0] dir_reg;
	logic [3:0] dir_next;
	logic [10:0] latch_reg;
	logic [10:0] latch_next;
	logic [15:0] scan_word_reg;
	logic [15:0] scan_word_next;
	logic scan_valid_reg;
	logic scan_valid_next;
	logic scan_blank_reg;
	logic scan_blank_next;
	logic cpu_clk_reg;
	logic character_dot_clock_reg;

	logic cpu_is_owner;
	logic stroke_hit;
	logic system_hit;
	logic latch_hit;
	logic [8:0] scan_pos;
	logic [AW-1:0] scan_addr;
	logic [AW-1:0] cpu_word_addr;
	logic [15:0] stroke_rd;
	logic cpu_reading;
	logic wr_ok;
	lane_e lane;

	assign cpu_is_owner = (owner_reg == OWN_CPU);
	assign stroke_hit = in_range(cpu_addr_in, `STROKE_LO, `STROKE_HI);
	assign system_hit = in_range(cpu_addr_in, `SCRATCH_LO, `TEXT_LO_HI);
	assign latch_hit = in_range(cpu_addr_in, `LATCH_LO, `LATCH_HI);
	// count bits 5..13 give position, bit 15 picks trace
	assign scan_pos = scan_count_in[13:5];
	assign scan_addr = {scan_count_in[15], scan_pos};
	// word index from cpu address bits 9..0
	assign cpu_word_addr = cpu_addr_in[AW-1:0];
	assign stroke_rd = stroke_mem[cpu_is_owner ? cpu_word_addr : scan_addr];
	// low read direction moves memory data toward the cpu
	assign cpu_reading = ~cpu_read_direction_n_in;
	// commands only with a15 low, write clock low, read direction high
	assign wr_ok = ~cpu_addr_in[15] & ~write_clock_in & cpu_read_direction_n_in;

	// 0x400.. blanking, 0x800.. upper byte, 0xc00.. lower byte
	always_comb begin
		lane = LANE_UPPER;
		unique case (cpu_addr_in[11:10])
			2'b01: lane = LANE_LOWER;
			2'b10: lane = LANE_UPPER;
			2'b11: lane = LANE_MIDDLE;
			default: lane = LANE_UPPER;
		endcase
	end

	always_comb begin
		owner_next = owner_reg;
		cpu_busy_next = cpu_busy_reg;
		steps_left_next = steps_left_reg;
		fast_next = fast_reg;
		cpu_data_next = cpu_data_reg;
		xcvr_next = 3'b111;
		stroke_cs_next = 1'b1;
		system_cs_next = 1'b1;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		oe_n_next = 1'b1;
		dir_next = 4'hf;
		latch_next = 11'h000;
		scan_word_next = scan_word_reg;
		scan_valid_next = 1'b0;
		scan_blank_next = scan_blank_reg;
		sys_read_next = 1'b0;
		// system ram answers while its select is low, so the byte is taken at the end of that cycle
		if (sys_read_reg) begin
			cpu_data_next = sys_word[7:0];
		end
		// owner flips only when no cpu transfer is open
		if (!cpu_busy_reg) begin
			if (cpu_access_in && (stroke_hit || system_hit)) begin
				owner_next = OWN_CPU;
				cpu_busy_next = 1'b1;
				steps_left_next = stroke_hit ? 2'd2 : 2'd0;
			end else if (scan_request_in) begin
				owner_next = OWN_SCAN;
			end
		end
		if (cpu_is_owner && cpu_access_in) begin
			addr_next = cpu_word_addr;
			xcvr_next = stroke_hit ? xcvr_decode(1'b1, cpu_addr_in) : 3'b110;
			// cpu drives the wide bus on writes
			oe_n_next = cpu_reading;
			if (stroke_hit) begin
				stroke_cs_next = 1'b0;
				unique case (lane)
					LANE_UPPER: begin
						wdata_next[15:8] = cpu_data_in;
						if (cpu_reading) begin
							cpu_data_next = stroke_rd[15:8];
						end
					end
					LANE_MIDDLE: begin
						wdata_next[7:4] = cpu_data_in[7:4];
						if (cpu_reading) begin
							cpu_data_next = {stroke_rd[7:4], 4'h0};
						end
					end
					LANE_LOWER: begin
						wdata_next[3:0] = cpu_data_in[7:4];
						if (cpu_reading) begin
							cpu_data_next = {stroke_rd[3:0], 4'h0};
						end
					end
				endcase
				if (wr_ok) begin
					unique case (lane)
						LANE_UPPER: dir_next = 4'b1110;
						LANE_MIDDLE: dir_next = 4'b1011;
						LANE_LOWER: dir_next = 4'b1101;
					endcase
				end
				if (steps_left_reg == 2'd0) begin
					cpu_busy_next = 1'b0;
				end else begin
					steps_left_next = steps_left_reg - 2'd1;
				end
			end else if (system_hit) begin
				system_cs_next = 1'b0;
				wdata_next = {8'h00, cpu_data_in};
				sys_read_next = cpu_reading;
				if (wr_ok) begin
					dir_next = 4'b0111;
				end
				cpu_busy_next = 1'b0;
			end
		end else if (!cpu_is_owner && scan_request_in) begin
			addr_next = scan_addr;
			stroke_cs_next = 1'b0;
			scan_word_next = stroke_rd & 16'hffcf;
			scan_valid_next = 1'b1;
			scan_blank_next = (scan_pos < `BLANK_LEFT) || (scan_pos > `BLANK_RIGHT);
		end
		if (cpu_is_owner && cpu_access_in && latch_hit) begin
			latch_next = 11'h001 << 4'(cpu_addr_in[4:0] - 5'h15);
			if (cpu_addr_in == `LATCH_FAST_OFF) begin
				fast_next = 1'b0;
			end else if (cpu_addr_in == `LATCH_FAST_ON) begin
				fast_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!oe_n_reg && !stroke_cs_reg) begin
			stroke_mem[addr_reg] <= wdata_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			owner_reg <= OWN_SCAN;
			cpu_busy_reg <= 1'b0;
			steps_left_reg <= 2'd0;
			fast_reg <= 1'b0;
			cpu_data_reg <= 8'h00;
			xcvr_reg <= 3'b111;
			stroke_cs_reg <= 1'b1;
			system_cs_reg <= 1'b1;
			addr_reg <= '0;
			wdata_reg <= 16'h0000;
			oe_n_reg <= 1'b1;
			dir_reg <= 4'hf;
			latch_reg <= 11'h000;
			scan_word_reg <= 16'h0000;
			scan_valid_reg <= 1'b0;
			scan_blank_reg <= 1'b1;
			sys_read_reg <= 1'b0;
			cpu_clk_reg <= 1'b0;
			character_dot_clock_reg <= 1'b0;
		end else begin
			owner_reg <= owner_next;
			cpu_busy_reg <= cpu_busy_next;
			steps_left_reg <= steps_left_next;
			fast_reg <= fast_next;
			cpu_data_reg <= cpu_data_next;
			xcvr_reg <= xcvr_next;
			stroke_cs_reg <= stroke_cs_next;
			system_cs_reg <= system_cs_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			oe_n_reg <= oe_n_next;
			dir_reg <= dir_next;
			latch_reg <= latch_next;
			scan_word_reg <= scan_word_next;
			scan_valid_reg <= scan_valid_next;
			scan_blank_reg <= scan_blank_next;
			sys_read_reg <= sys_read_next;
			cpu_clk_reg <= cpu_wave;
			character_dot_clock_reg <= dot_wave;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign cpu_data_out = cpu_data_reg;
	assign memory_owner_out = (owner_reg == OWN_CPU);
	// rom only while the counter owns memory
	assign rom_enable_n_out = (owner_reg == OWN_SCAN) ? 1'b0 : 1'b1;
	assign xcvr_enable_n_out = xcvr_reg;
	// one chip select from either source
	assign stroke_cs_n_out = stroke_cs_reg;
	assign system_cs_n_out = system_cs_reg;
	assign mem_addr_out = addr_reg;
	assign mem_data_out = wdata_reg;
	assign mem_data_oe_n_out = oe_n_reg;
	assign upper_lane_direction_out = dir_reg[0];
	assign blank_lane_direction_out = dir_reg[1];
	assign lower_lane_direction_out = dir_reg[2];
	assign system_direction_out = dir_reg[3];
	assign latch_strobe_out = latch_reg;
	assign fast_sweep_enable_out = fast_reg;
	assign scan_word_out = scan_word_reg;
	assign scan_word_valid_out = scan_valid_reg;
	assign scan_blank_out = scan_blank_reg;
	assign cpu_clock_out = cpu_clk_reg;
	assign character_dot_clock_out = character_dot_clock_reg;
endmodule : display_memory_access_mux
`default_nettype wire

// File: verilog/memory_fabric_map.svh
// constants for the display memory access fabric
// What this block does
// - owner select high: cpu addresses shared memory, rom off, cpu drives data bus
// - owner select low: refresh counter addresses memory and owns bus, rom on
// - read direction low passes memory data toward cpu, else cpu to memory
// - timing clocks run at 2 mhz, dot clock at 4 mhz
// - system memory access is one byte via first transceiver only
// - stroke step one: first transceiver, cpu d7..d0 to memory bits 15..8
// - stroke step two: second transceiver, memory bits 7..4 on cpu d7..d4
// - stroke step three: third transceiver, memory bits 3..0 on cpu d7..d4
// - transceiver decoder active only with owner high; a10,a11 pick one low output
// - stroke memory holds 1024 16-bit words, 512 per trace, 10-bit address
// - stroke word: vertical 15..8 and 7..6, fractions 5..4, blanking below
// - blanking suppresses extreme left and right horizontal positions
// - counter addresses stroke memory with count bits 5..13 plus trace bit 15
// - address multiplexers pick a inputs when owner low, b inputs when high
// - stroke chip select muxed from cpu or scan select; low enables rams
// - cpu controls stroke memory when owner high and cpu stroke select low
// - counter controls stroke memory when scan select and owner both low
// - separate direction lines for upper byte rams and lower byte ram
// - control latch actions decoded at 0x15 to 0x1f
// - stroke map: 512-byte regions from 0x400, trace b before trace a
// - system map: scratch 0x40-0x37f, upper text 0x380-0x3bf, lower 0x3c0-0x3ff
// - four direction commands one at a time: a15, write clock low, read dir high
`ifndef MEMORY_FABRIC_MAP_SVH
`define MEMORY_FABRIC_MAP_SVH
`define CLK_HZ 200000000
`define CPU_CLOCK_HZ 2000000
`define DOT_CLOCK_HZ 4000000
`define CPU_CLOCK_HALF (`CLK_HZ / `CPU_CLOCK_HZ / 2)
`define DOT_CLOCK_HALF (`CLK_HZ / `DOT_CLOCK_HZ / 2)
`define SCRATCH_LO 16'h0040
`define SCRATCH_HI 16'h037f
`define TEXT_UP_LO 16'h0380
`define TEXT_UP_HI 16'h03bf
`define TEXT_LO_LO 16'h03c0
`define TEXT_LO_HI 16'h03ff
`define STROKE_LO 16'h0400
`define STROKE_HI 16'h0fff
`define LATCH_LO 16'h0015
`define LATCH_HI 16'h001f
`define LATCH_FAST_OFF 16'h0015
`define LATCH_FAST_ON 16'h0017
`define LATCH_TRIGGER 16'h0019
`define LATCH_ARM 16'h0018
`define ROM_LO 16'he000
`define BLANK_LEFT 9'h010
`define BLANK_RIGHT 9'h1f0
`endif

// File: verilog/memory_fabric_pkg.sv
// types for the display memory access fabric
package memory_fabric_pkg;
	typedef enum logic [2:0] {
		LANE_UPPER = 3'b001,
		LANE_MIDDLE = 3'b010,
		LANE_LOWER = 3'b100
	} lane_e;
	typedef enum logic [1:0] {
		OWN_SCAN = 2'b01,
		OWN_CPU = 2'b10
	} owner_e;
endpackage : memory_fabric_pkg
